/* File: hw/fa_feed_regs.sv */
// Decided for this implementation: the AHB-Lite register port and the address map.
`timescale 1ns/10ps
// Operation
// RULE1 - Positioning amount: 28-bit signed, read-write
// RULE2 - Positioning amount is move target normally
// RULE3 - In interpolation, it is incremental X end
// RULE4 - Separately addressable pre-register before active one
// RULE5 - Active write during move overrides remaining feed
// RULE6 - Y positioning amount: 28-bit signed, read-write
// RULE7 - Circle centre X: 28-bit signed, read-write
// RULE8 - Circle centre Y: 28-bit signed, read-write
// RULE9 - Circle step total: 31-bit unsigned, read-write
// RULE10 - Circle step counter: 31-bit, read-only
// RULE11 - Pre-registers move to active at operation start
module fa_feed_regs
    import fa_pkg::*;
#(
    parameter int AMT_W = FA_AMT_W,
    parameter int STEP_W = FA_STEP_W
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Axis core side
    input wire fa_core_t core_in,
    output fa_axis_t axis_out,
    output logic [27:0] pos_target,
    output logic [27:0] x_end_incr,
    output logic feed_override,
    output logic [30:0] step_count
);

    // ==========================================================
    // Helper functions
    // ==========================================================
    // Word-aligned byte offset from a bus address
    function automatic logic [7:0] fa_ofs(input logic [31:0] addr);
        fa_ofs = {addr[7:2], 2'h0};
    endfunction : fa_ofs

    // Zero-extend a 28-bit amount into a bus word
    function automatic logic [31:0] fa_amt_word(input logic [27:0] v);
        fa_amt_word = {4'h0, v};
    endfunction : fa_amt_word

    // Zero-extend a 31-bit count into a bus word
    function automatic logic [31:0] fa_step_word(input logic [30:0] v);
        fa_step_word = {1'h0, v};
    endfunction : fa_step_word

    // Data-phase write that targets one register word
    // Shared by every active register so all decode the same way
    function automatic logic fa_wr_hit(
        input logic en,
        input logic [7:0] ofs,
        input logic [7:0] target
    );
        fa_wr_hit = en && (ofs == target);
    endfunction : fa_wr_hit

    // ==========================================================
    // Storage
    // ==========================================================
    // Every value sits in flip-flops; each pre-register has an active twin
    logic [27:0] feed_amount_pre_ff;     // Pre-register, positioning
    logic [27:0] feed_amount_ff;         // Active, positioning
    logic [27:0] y_feed_amount_pre_ff;   // Pre-register, Y amount
    logic [27:0] y_feed_amount_ff;       // Active, Y amount
    logic [27:0] circle_center_x_pre_ff; // Pre-register, centre X
    logic [27:0] circle_center_x_ff;     // Active, centre X
    logic [27:0] circle_center_y_pre_ff; // Pre-register, centre Y
    logic [27:0] circle_center_y_ff;     // Active, centre Y
    logic [30:0] circle_step_total_pre_ff; // Pre-register, step total
    logic [30:0] circle_step_total_ff;     // Active, step total
    logic [30:0] circle_step_counter_ff;   // Executed steps
    logic feed_override_ff;               // Override pulse

    // ==========================================================
    // Bus address phase capture
    // ==========================================================
    // The bus is pipelined: a write's address comes one cycle before
    // its data, so the offset is kept until the data phase.
    logic addr_valid;         // Valid transfer this address phase
    logic wr_pend_ff;         // Write data phase pending
    logic [7:0] wr_ofs_ff;    // Offset of pending write
    logic [31:0] rdata_ff;    // Registered read data
    logic [31:0] nxt_rdata;   // Read mux output

    // Transfer accepted when selected, active and bus ready
    // IDLE and BUSY transfers are ignored
    assign addr_valid = hsel && hready &&
                        ((htrans == FA_HTRANS_NONSEQ) || (htrans == FA_HTRANS_SEQ));

    // Zero wait states, always OKAY
    // No register needs more than one cycle to answer
    assign hreadyout = 1'h1;
    assign hresp = FA_HRESP_OKAY;
    assign hrdata = rdata_ff;

    // Write strobes for the data phase
    logic wr_en;
    assign wr_en = wr_pend_ff;

    // Latch write address for the following data phase
    // Held while ce is low so a frozen bus keeps its pending write
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wr_pend_ff <= 1'h0;
            wr_ofs_ff <= 8'h00;
        end else if (ce) begin
            if (hready) begin
                // New address phase replaces the old one
                wr_pend_ff <= addr_valid && hwrite;
                wr_ofs_ff <= fa_ofs(haddr);
            end
        end
    end

    // ==========================================================
    // Read mux, sampled in the address phase
    // ==========================================================
    // Hazard: a read taken in the data phase of a write to the same
    // word returns the old value; software leaves one idle cycle
    always_comb begin
        nxt_rdata = FA_RDATA_RST;
        case (fa_ofs(haddr))
            FA_OFS_FEED_PRE: begin
                nxt_rdata = fa_amt_word(feed_amount_pre_ff); // RULE4
            end
            FA_OFS_FEED: begin
                nxt_rdata = fa_amt_word(feed_amount_ff); // RULE1
            end
            FA_OFS_YFEED_PRE: begin
                nxt_rdata = fa_amt_word(y_feed_amount_pre_ff);
            end
            FA_OFS_YFEED: begin
                nxt_rdata = fa_amt_word(y_feed_amount_ff); // RULE6
            end
            FA_OFS_CX_PRE: begin
                nxt_rdata = fa_amt_word(circle_center_x_pre_ff);
            end
            FA_OFS_CX: begin
                nxt_rdata = fa_amt_word(circle_center_x_ff); // RULE7
            end
            FA_OFS_CY_PRE: begin
                nxt_rdata = fa_amt_word(circle_center_y_pre_ff);
            end
            FA_OFS_CY: begin
                nxt_rdata = fa_amt_word(circle_center_y_ff); // RULE8
            end
            FA_OFS_STEPS_PRE: begin
                nxt_rdata = fa_step_word(circle_step_total_pre_ff);
            end
            FA_OFS_STEPS: begin
                nxt_rdata = fa_step_word(circle_step_total_ff); // RULE9
            end
            FA_OFS_STEP_CNT: begin
                nxt_rdata = fa_step_word(circle_step_counter_ff); // RULE10
            end
            FA_OFS_STATUS: begin
                // Core state bits
                // Lets software see whether a move is still running
                nxt_rdata[FA_STAT_RUN_BIT] = core_in.running;
                nxt_rdata[FA_STAT_INTERP_BIT] = core_in.interp;
                nxt_rdata[FA_STAT_CIRC_BIT] = core_in.circ;
            end
            default: begin
                // Unmapped reads return zero
                nxt_rdata = FA_RDATA_RST;
            end
        endcase
    end

    // Register read data for the data phase
    // Held until the next read is taken, so a slow master still sees it
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdata_ff <= FA_RDATA_RST;
        end else if (ce) begin
            if (addr_valid && !hwrite) begin
                rdata_ff <= nxt_rdata;
            end
        end
    end

    // ==========================================================
    // Pre-registers
    // ==========================================================
    // Written only by software, separate offsets from active ones
    // Software stages the next move here while the current one runs
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            feed_amount_pre_ff <= FA_AMT_RST;
            y_feed_amount_pre_ff <= FA_AMT_RST;
            circle_center_x_pre_ff <= FA_AMT_RST;
            circle_center_y_pre_ff <= FA_AMT_RST;
            circle_step_total_pre_ff <= FA_STEP_RST;
        end else if (ce && wr_en) begin
            case (wr_ofs_ff)
                FA_OFS_FEED_PRE: begin
                    feed_amount_pre_ff <= hwdata[27:0]; // RULE4
                end
                FA_OFS_YFEED_PRE: begin
                    y_feed_amount_pre_ff <= hwdata[27:0]; // RULE4
                end
                FA_OFS_CX_PRE: begin
                    circle_center_x_pre_ff <= hwdata[27:0]; // RULE4
                end
                FA_OFS_CY_PRE: begin
                    circle_center_y_pre_ff <= hwdata[27:0]; // RULE4
                end
                FA_OFS_STEPS_PRE: begin
                    circle_step_total_pre_ff <= hwdata[30:0]; // RULE4
                end
                default: begin
                    // Other offsets leave pre-registers alone
                end
            endcase
        end
    end

    // ==========================================================
    // Active positioning amount
    // ==========================================================
    // Operation start loads the pre-register; a direct write wins
    // so software can retarget a move in the very edge it starts
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            feed_amount_ff <= FA_AMT_RST;
        end else if (ce) begin
            if (fa_wr_hit(wr_en, wr_ofs_ff, FA_OFS_FEED)) begin
                feed_amount_ff <= hwdata[27:0]; // RULE1
            end else if (core_in.op_start) begin
                feed_amount_ff <= feed_amount_pre_ff; // RULE11
            end
        end
    end

    // Override pulse when active amount is rewritten mid-move
    // The core uses it to recompute the remaining feed
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            feed_override_ff <= 1'h0;
        end else if (ce) begin
            feed_override_ff <= fa_wr_hit(wr_en, wr_ofs_ff, FA_OFS_FEED) &&
                                core_in.running; // RULE5
        end
    end

    // ==========================================================
    // Active interpolation values
    // ==========================================================
    // Y amount and circle centre, same load scheme
    // Each register may be written apart from the others
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            y_feed_amount_ff <= FA_AMT_RST;
            circle_center_x_ff <= FA_AMT_RST;
            circle_center_y_ff <= FA_AMT_RST;
        end else if (ce) begin
            // Y end point
            if (fa_wr_hit(wr_en, wr_ofs_ff, FA_OFS_YFEED)) begin
                y_feed_amount_ff <= hwdata[27:0]; // RULE6
            end else if (core_in.op_start) begin
                y_feed_amount_ff <= y_feed_amount_pre_ff; // RULE11
            end
            // Centre X
            if (fa_wr_hit(wr_en, wr_ofs_ff, FA_OFS_CX)) begin
                circle_center_x_ff <= hwdata[27:0]; // RULE7
            end else if (core_in.op_start) begin
                circle_center_x_ff <= circle_center_x_pre_ff; // RULE11
            end
            // Centre Y
            if (fa_wr_hit(wr_en, wr_ofs_ff, FA_OFS_CY)) begin
                circle_center_y_ff <= hwdata[27:0]; // RULE8
            end else if (core_in.op_start) begin
                circle_center_y_ff <= circle_center_y_pre_ff; // RULE11
            end
        end
    end

    // Circular step total
    // Loaded with the rest so a circle always sees a matching set
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            circle_step_total_ff <= FA_STEP_RST;
        end else if (ce) begin
            if (fa_wr_hit(wr_en, wr_ofs_ff, FA_OFS_STEPS)) begin
                circle_step_total_ff <= hwdata[30:0]; // RULE9
            end else if (core_in.op_start) begin
                circle_step_total_ff <= circle_step_total_pre_ff; // RULE11
            end
        end
    end

    // ==========================================================
    // Circular step counter
    // ==========================================================
    // Saturating keeps a runaway count from wrapping back to zero
    // Cleared at start of each operation, counts executed steps,
    // holds at its maximum; software cannot write it
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            circle_step_counter_ff <= FA_STEP_RST;
        end else if (ce) begin
            if (core_in.op_start) begin
                circle_step_counter_ff <= FA_STEP_RST; // RULE10
            end else if (core_in.step && core_in.circ &&
                         (circle_step_counter_ff != FA_STEP_MAX)) begin
                circle_step_counter_ff <= circle_step_counter_ff + 31'h00000001; // RULE10
            end
        end
    end

    // ==========================================================
    // Outputs to the axis core
    // ==========================================================
    // Active set as one bundle
    assign axis_out.feed = feed_amount_ff;
    assign axis_out.y_feed = y_feed_amount_ff;
    assign axis_out.center_x = circle_center_x_ff;
    assign axis_out.center_y = circle_center_y_ff;
    assign axis_out.steps_total = circle_step_total_ff;

    // Same register, meaning set by mode; unused view reads zero
    // so the core cannot mix up a target and an X end point
    assign pos_target = core_in.interp ? FA_AMT_RST : feed_amount_ff; // RULE2
    assign x_end_incr = core_in.interp ? feed_amount_ff : FA_AMT_RST; // RULE3

    assign feed_override = feed_override_ff; // RULE5
    assign step_count = circle_step_counter_ff;

endmodule : fa_feed_regs

/* File: hw/fa_pkg.sv */
package fa_pkg;

    // ==========================================================
    // Widths
    // ==========================================================
    localparam int FA_AMT_W = 28;   // Signed feed amounts
    localparam int FA_STEP_W = 31;  // Circular step count
    localparam int FA_ADDR_W = 8;   // Decoded byte address bits

    // ==========================================================
    // Register byte offsets
    // ==========================================================
    localparam logic [7:0] FA_OFS_FEED_PRE = 8'h00;
    localparam logic [7:0] FA_OFS_FEED = 8'h04;
    localparam logic [7:0] FA_OFS_YFEED_PRE = 8'h08;
    localparam logic [7:0] FA_OFS_YFEED = 8'h0C;
    localparam logic [7:0] FA_OFS_CX_PRE = 8'h10;
    localparam logic [7:0] FA_OFS_CX = 8'h14;
    localparam logic [7:0] FA_OFS_CY_PRE = 8'h18;
    localparam logic [7:0] FA_OFS_CY = 8'h1C;
    localparam logic [7:0] FA_OFS_STEPS_PRE = 8'h20;
    localparam logic [7:0] FA_OFS_STEPS = 8'h24;
    localparam logic [7:0] FA_OFS_STEP_CNT = 8'h28;
    localparam logic [7:0] FA_OFS_STATUS = 8'h2C;

    // ==========================================================
    // Reset values and bus constants
    // ==========================================================
    localparam logic [27:0] FA_AMT_RST = 28'h0000000;
    localparam logic [30:0] FA_STEP_RST = 31'h00000000;
    localparam logic [30:0] FA_STEP_MAX = 31'h7FFFFFFF;
    localparam logic [31:0] FA_RDATA_RST = 32'h00000000;
    localparam logic [1:0] FA_HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] FA_HTRANS_SEQ = 2'h3;
    localparam logic FA_HRESP_OKAY = 1'h0;

    // Status word bit positions
    localparam int FA_STAT_RUN_BIT = 0;
    localparam int FA_STAT_INTERP_BIT = 1;
    localparam int FA_STAT_CIRC_BIT = 2;

    // ==========================================================
    // Carriers
    // ==========================================================
    // Active values handed to the axis core
    typedef struct packed {
        logic [27:0] feed;        // Target or X end point
        logic [27:0] y_feed;      // Y end point
        logic [27:0] center_x;    // Circle centre X
        logic [27:0] center_y;    // Circle centre Y
        logic [30:0] steps_total; // Circular step count
    } fa_axis_t;

    // Events and state reported by the axis core
    typedef struct packed {
        logic op_start;  // Pulse: next operation begins
        logic running;   // Level: move in progress
        logic interp;    // Level: linear or circular interpolation
        logic circ;      // Level: circular interpolation
        logic step;      // Pulse: one circular step executed
    } fa_core_t;

endpackage : fa_pkg

/* File: dv/fa_feed_regs_props.sv */
`timescale 1ns/10ps
// ==========================================================
// Feed register checker
// ==========================================================
module fa_feed_regs_props
    import fa_pkg::*;
#(
    parameter int AMT_W = FA_AMT_W,
    parameter int STEP_W = FA_STEP_W
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    input wire fa_core_t core_in,
    input wire fa_axis_t axis_out,
    input wire logic [27:0] pos_target,
    input wire logic [27:0] x_end_incr,
    input wire logic feed_override,
    input wire logic [30:0] step_count
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    logic take;       // Address phase accepted
    logic wr_feed_ff; // Data phase of active feed write
    logic rd_cnt_ff;  // Data phase of counter read
    logic ovr_cause;  // Active feed write while moving

    assign take = ce && hsel && hready && htrans[1];
    assign ovr_cause = ce && wr_feed_ff && core_in.running;

    // Track data phases of interest
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wr_feed_ff <= 1'h0;
            rd_cnt_ff <= 1'h0;
        end else if (ce) begin
            wr_feed_ff <= take && hwrite && haddr[7:2] == FA_OFS_FEED[7:2];
            rd_cnt_ff <= take && !hwrite && haddr[7:2] == FA_OFS_STEP_CNT[7:2];
        end
    end

    // ==========================================================
    // Properties
    // ==========================================================
    a_target_mux: assert property (
        pos_target == (core_in.interp ? FA_AMT_RST : axis_out.feed))
        else $error("target output mismatch");
    a_xend_mux: assert property (
        x_end_incr == (core_in.interp ? axis_out.feed : FA_AMT_RST))
        else $error("x end output mismatch");
    a_feed_write: assert property (
        ce && wr_feed_ff |=> axis_out.feed == $past(hwdata[27:0]))
        else $error("active feed write lost");
    a_override_on: assert property (
        ovr_cause |=> feed_override)
        else $error("override pulse missing");
    a_override_cause: assert property (
        feed_override |-> $past(ovr_cause))
        else $error("override pulse without cause");
    a_step_clear: assert property (
        ce && core_in.op_start |=> step_count == FA_STEP_RST)
        else $error("counter not cleared");
    a_step_incr: assert property (
        ce && !core_in.op_start && core_in.step && core_in.circ
        && step_count != FA_STEP_MAX |=> step_count == $past(step_count) + 31'h1)
        else $error("counter did not advance");
    a_step_hold: assert property (
        !(ce && (core_in.op_start || (core_in.step && core_in.circ)))
        |=> $stable(step_count))
        else $error("counter moved without step");
    a_cnt_read: assert property (
        rd_cnt_ff |-> hrdata == {1'h0, $past(step_count)})
        else $error("counter read mismatch");
endmodule : fa_feed_regs_props

bind fa_feed_regs fa_feed_regs_props #(.AMT_W(AMT_W), .STEP_W(STEP_W)) i_fa_feed_regs_props (
    .clk(clk), .nrst(nrst), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .core_in(core_in),
    .axis_out(axis_out), .pos_target(pos_target), .x_end_incr(x_end_incr),
    .feed_override(feed_override), .step_count(step_count));

/* File: dv/fa_feed_regs_tb_top.sv */
`timescale 1ns/10ps
module fa_feed_regs_tb_top
    import fa_pkg::*;
;
    // ==========================================================
    // Stimulus and observed signals
    // ==========================================================
    logic clk = 1'h0;
    logic nrst = 1'h0;
    logic ce = 1'h1;
    logic hsel = 1'h0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'h0;
    logic [2:0] hsize = 3'h2; // Whole words only
    logic [31:0] hwdata = 32'h0;
    logic hready;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    fa_core_t core = '0;
    fa_axis_t axis;
    logic [27:0] pos_target;
    logic [27:0] x_end_incr;
    logic feed_override;
    logic [30:0] step_count;
    logic [31:0] rd;        // Last read data
    logic [31:0] exp_v [10]; // Written values, masked
    int mismatches = 0;
    int compares = 0;

    // 25 MHz clock
    always #20 clk = ~clk;
    // Single slave drives bus ready
    assign hready = hreadyout;

    fa_feed_regs i_fa_feed_regs (
        .clk(clk), .nrst(nrst), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .core_in(core),
        .axis_out(axis), .pos_target(pos_target), .x_end_incr(x_end_incr),
        .feed_override(feed_override), .step_count(step_count));

    // ==========================================================
    // Tasks
    // ==========================================================
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // Wait for ready, bounded
    task automatic wait_rdy();
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (hready !== 1'h1 && n < 64);
        if (hready !== 1'h1) mismatches++;
    endtask : wait_rdy

    // One single AHB-Lite transfer
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1'h1;
        haddr <= {24'h0, a};
        htrans <= FA_HTRANS_NONSEQ;
        hwrite <= w;
        wait_rdy();
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy();
        rd = hrdata;
        check({31'h0, hresp}, 32'h0);
    endtask : bus

    task automatic results();
        $display("mismatches=%0d compares=%0d", mismatches, compares);
        if (mismatches == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : results

    // Watchdog
    initial begin
        #200000;
        mismatches++;
        results();
    end

    // ==========================================================
    // Main sequence
    // ==========================================================
    initial begin
        repeat (10) @(posedge clk);
        nrst <= 1'h1;
        @(posedge clk);
        // Reset values
        for (int i = 0; i < 12; i++) begin
            bus(1'h0, 8'(i * 4), 32'h0);
            check(rd, 32'h0);
        end
        // Near-limit values into every writable word
        for (int i = 0; i < 10; i++) begin
            exp_v[i] = (i % 2 == 1) ? 32'h87FFFFF0 + 32'(i) : 32'hF8000000 + 32'(i);
            bus(1'h1, 8'(i * 4), exp_v[i]);
            exp_v[i] &= (i < 8) ? 32'h0FFFFFFF : 32'h7FFFFFFF;
        end
        bus(1'h1, FA_OFS_STEP_CNT, 32'h12345678);
        bus(1'h1, 8'h40, 32'hFFFFFFFF);
        for (int i = 0; i < 11; i++) begin
            bus(1'h0, 8'(i * 4), 32'h0);
            check(rd, (i < 10) ? exp_v[i] : 32'h0);
        end
        bus(1'h0, 8'h40, 32'h0);
        check(rd, 32'h0);
        // Target versus X end point
        #1;
        check({4'h0, pos_target}, exp_v[1]);
        check({4'h0, x_end_incr}, 32'h0);
        @(posedge clk);
        core.interp <= 1'h1;
        #1;
        check({4'h0, pos_target}, 32'h0);
        check({4'h0, x_end_incr}, exp_v[1]);
        // Steps: counted, ignored off circle, frozen
        @(posedge clk);
        core.circ <= 1'h1;
        core.step <= 1'h1;
        repeat (5) @(posedge clk);
        core.circ <= 1'h0;
        repeat (2) @(posedge clk);
        ce <= 1'h0;
        core.circ <= 1'h1;
        repeat (2) @(posedge clk);
        ce <= 1'h1;
        core.step <= 1'h0;
        #1;
        check({1'h0, step_count}, 32'h5);
        @(posedge clk);
        bus(1'h0, FA_OFS_STEP_CNT, 32'h0);
        check(rd, 32'h5);
        // Next operation loads pre values
        core.op_start <= 1'h1;
        @(posedge clk);
        core.op_start <= 1'h0;
        #1;
        check({4'h0, axis.feed}, exp_v[0]);
        check({4'h0, axis.y_feed}, exp_v[2]);
        check({4'h0, axis.center_x}, exp_v[4]);
        check({4'h0, axis.center_y}, exp_v[6]);
        check({1'h0, axis.steps_total}, exp_v[8]);
        check({1'h0, step_count}, 32'h0);
        // Override while moving
        @(posedge clk);
        core.running <= 1'h1;
        bus(1'h1, FA_OFS_FEED, 32'h0ABCDEF1);
        #1;
        check({31'h0, feed_override}, 32'h1);
        check({4'h0, x_end_incr}, 32'h0ABCDEF1);
        @(posedge clk);
        #1;
        check({31'h0, feed_override}, 32'h0);
        // Status while moving in circular interpolation
        @(posedge clk);
        bus(1'h0, FA_OFS_STATUS, 32'h0);
        check(rd, 32'h7);
        // No override when stopped
        core.running <= 1'h0;
        bus(1'h1, FA_OFS_FEED, 32'h00000007);
        #1;
        check({31'h0, feed_override}, 32'h0);
        @(posedge clk);
        bus(1'h0, FA_OFS_FEED, 32'h0);
        check(rd, 32'h7);
        results();
    end
endmodule : fa_feed_regs_tb_top
